// [src/lhic_defs.svh]
// Constants for the limit and homing input configuration block.
// Assumes a single 50 MHz clock; the includer picks the names it needs.
`ifndef LHIC_DEFS_SVH
`define LHIC_DEFS_SVH

// Object indices and subindices.
`define LHIC_IDX_INPUT_CFG 16'h2310
`define LHIC_IDX_INPUT_STAT 16'h2311
`define LHIC_IDX_FAULT_PIN 16'h2315
`define LHIC_IDX_THRESHOLD 16'h2316
`define LHIC_SUB_COUNT 8'h00
`define LHIC_SUB_LOWER 8'h01
`define LHIC_SUB_UPPER 8'h02
`define LHIC_SUB_HOMING 8'h03
`define LHIC_SUB_EDGE 8'h05
`define LHIC_SUB_HLIMIT 8'h06
`define LHIC_SUB_STAT_LOGIC 8'h01
`define LHIC_SUB_STAT_RAW 8'h02
`define LHIC_SUB_FAULT_FN 8'h01

// Reset values and fixed entry counts.
`define LHIC_RST_COUNT 8'h06
`define LHIC_RST_LOWER 8'h00
`define LHIC_RST_UPPER 8'h00
`define LHIC_RST_HOMING 8'h07
`define LHIC_RST_EDGE 8'h07
`define LHIC_RST_HLIMIT 8'h00
`define LHIC_RST_THRESH 8'h01
`define LHIC_RST_FAULT_FN 8'h00
`define LHIC_STAT_COUNT 8'h04
`define LHIC_FAULT_COUNT 8'h03

// Mask bit positions.
`define LHIC_BIT_ANALOG 0
`define LHIC_BIT_FAULT 1
`define LHIC_BIT_THIRD 2

// Fault pin function code for reference input, and operating modes.
`define LHIC_FAULT_FN_REF 8'h04
`define LHIC_MODE_PROFILE_POS 8'h01
`define LHIC_MODE_PROFILE_VEL 8'h03

// Timing: clock rate, level sampling period and the response bound.
`define LHIC_CLK_MHZ 50
`define LHIC_SAMPLE_US 200
`define LHIC_RESPONSE_US 500

`endif

// [src/lhic_pkg.sv]
// Types shared by the limit and homing input configuration block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package lhic_pkg;
    // One bit per physical input; bits 3 to 7 carry no input.
    typedef logic [7:0] lhic_mask_t;
    // Answer of the object access port.
    typedef enum logic [1:0] {LHIC_ANS_NONE, LHIC_ANS_OK, LHIC_ANS_ERR} lhic_ans_t;
endpackage : lhic_pkg

`default_nettype wire

// [src/lhic_sync_in.sv]
// Two flip-flop synchroniser, one per external input bit.
// Assumes inputs arrive from outside the clk_i domain.
`default_nettype none

module lhic_sync_in #(
    parameter int WIDTH = 3
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    genvar g;
    // Each bit gets its own pair; the first stage feeds only the second.
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic meta_ff;
            logic sync_ff;
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    meta_ff <= 1'b0;
                    sync_ff <= 1'b0;
                end else begin
                    meta_ff <= d_i[g];
                    sync_ff <= meta_ff;
                end
            end
            assign q_o[g] = sync_ff;
        end
    endgenerate
endmodule : lhic_sync_in

`default_nettype wire

// [src/lhic_top.sv]
// Limit, homing and index input conditioning with its configuration objects.
// Assumes switch pins are asynchronous and the motion core is on clk_i.
`default_nettype none
`include "lhic_defs.svh"

module lhic_top #(
    parameter int SAMPLE_CYC = `LHIC_SAMPLE_US * `LHIC_CLK_MHZ
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic analog_input_pin_i,
    input wire logic fault_pin_i,
    input wire logic third_input_i,
    input wire logic hall_sign_i,
    input wire logic [7:0] op_mode_i,
    input wire logic move_pos_req_i,
    input wire logic move_neg_req_i,
    input wire logic homing_start_i,
    input wire logic [7:0] homing_method_i,
    input wire logic [15:0] obj_index_i,
    input wire logic [7:0] obj_sub_i,
    input wire logic obj_wr_i,
    input wire logic obj_rd_i,
    input wire logic [7:0] obj_wdata_i,
    output logic obj_ack_o,
    output logic obj_err_o,
    output logic [7:0] obj_rdata_o,
    output logic thresh_24v_o,
    output logic fault_pin_is_input_o,
    output logic lower_limit_o,
    output logic upper_limit_o,
    output logic homing_lower_o,
    output logic homing_upper_o,
    output logic homing_switch_o,
    output logic move_pos_en_o,
    output logic move_neg_en_o,
    output logic stop_o,
    output logic hall_index_o,
    output logic position_zero_o,
    output logic homing_go_o,
    output logic homing_refused_o
);
    // The level sample period must stay inside the response bound.
    localparam int RESPONSE_CYC = `LHIC_RESPONSE_US * `LHIC_CLK_MHZ;
    // Past that bound the tick is clamped to half of it, leaving margin for the synchroniser.
    localparam int TICK_CYC = (SAMPLE_CYC > RESPONSE_CYC) ? (RESPONSE_CYC / 2) : SAMPLE_CYC;
    localparam int CNT_W = $clog2(SAMPLE_CYC + 1);

    lhic_pkg::lhic_mask_t lower_sel_ff;
    lhic_pkg::lhic_mask_t upper_sel_ff;
    lhic_pkg::lhic_mask_t homing_sel_ff;
    lhic_pkg::lhic_mask_t edge_sense_ff;
    logic [7:0] hlimit_apply_ff;
    logic [7:0] thresh_ff;
    logic [7:0] fault_fn_ff;
    logic [2:0] pin_sync;
    logic [2:0] raw_ff;
    logic [2:0] prev_ff;
    logic [CNT_W-1:0] tick_cnt_ff;
    logic tick;
    logic hall_prev_ff;
    logic lower_prev_ff;
    logic upper_prev_ff;
    logic cfg_open;
    logic hit_cfg;
    logic [7:0] rd_val;
    logic rd_ok;
    logic wr_ok;
    lhic_pkg::lhic_ans_t ans_ff;
    logic [7:0] rdata_ff;
    lhic_pkg::lhic_mask_t raw_mask;
    lhic_pkg::lhic_mask_t logic_mask;
    lhic_pkg::lhic_mask_t home_pol_mask;
    lhic_pkg::lhic_mask_t role_ok;
    logic [2:0] rise;
    logic [2:0] fall;
    logic need_lower;
    logic need_upper;
    logic need_home;

    // Synchronise the three switch pins before anything looks at them.
    lhic_sync_in #(
        .WIDTH(3)
    ) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i({third_input_i, fault_pin_i, analog_input_pin_i}),
        .q_o(pin_sync)
    );

    // Divider for the level sampling tick; one cycle wide.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_cnt_ff <= '0;
        end else if (tick) begin
            tick_cnt_ff <= '0;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + CNT_W'(1);
        end
    end
    assign tick = (tick_cnt_ff == CNT_W'(TICK_CYC - 1));

    // Edge inputs track every clock so no short interrupt edge is missed; the
    // third input is only sampled on the tick, which holds its reaction well
    // inside the response bound while ignoring pulses the source should not make.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            raw_ff <= 3'h0;
            prev_ff <= 3'h0;
        end else begin
            raw_ff[`LHIC_BIT_ANALOG] <= pin_sync[`LHIC_BIT_ANALOG];
            raw_ff[`LHIC_BIT_FAULT] <= pin_sync[`LHIC_BIT_FAULT];
            if (tick) begin
                raw_ff[`LHIC_BIT_THIRD] <= pin_sync[`LHIC_BIT_THIRD];
            end
            prev_ff <= raw_ff;
        end
    end

    // Edge events of the edge-evaluated inputs.
    assign rise = raw_ff & ~prev_ff;
    assign fall = ~raw_ff & prev_ff;

    // Raw levels, states after edge-sense polarity, and homing-limit polarity.
    always_comb begin
        raw_mask = {5'h00, raw_ff};
        logic_mask = ~(raw_mask ^ edge_sense_ff) & 8'h07;
        if (hlimit_apply_ff[0]) begin
            home_pol_mask = logic_mask;
        end else begin
            home_pol_mask = raw_mask;
        end
        role_ok = 8'h07;
        if (fault_fn_ff != `LHIC_FAULT_FN_REF) begin
            role_ok[`LHIC_BIT_FAULT] = 1'b0;
        end
    end

    // Switch roles as seen by the motion and homing logic.
    assign lower_limit_o = |(lower_sel_ff & role_ok & logic_mask);
    assign upper_limit_o = |(upper_sel_ff & role_ok & logic_mask);
    assign homing_lower_o = |(lower_sel_ff & role_ok & home_pol_mask);
    assign homing_upper_o = |(upper_sel_ff & role_ok & home_pol_mask);
    assign homing_switch_o = |(homing_sel_ff & role_ok & raw_mask);

    // Travel gating: a limit blocks only the direction that goes deeper into it.
    assign move_neg_en_o = move_neg_req_i & ~lower_limit_o;
    assign move_pos_en_o = move_pos_req_i & ~upper_limit_o;

    // Stop pulse on the cycle after either limit engages.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lower_prev_ff <= 1'b0;
            upper_prev_ff <= 1'b0;
            stop_o <= 1'b0;
        end else begin
            lower_prev_ff <= lower_limit_o;
            upper_prev_ff <= upper_limit_o;
            stop_o <= (lower_limit_o & ~lower_prev_ff) | (upper_limit_o & ~upper_prev_ff);
        end
    end

    // Hall zero crossing and external index pulses, both one cycle wide.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hall_prev_ff <= 1'b0;
            hall_index_o <= 1'b0;
            position_zero_o <= 1'b0;
        end else begin
            hall_prev_ff <= hall_sign_i;
            hall_index_o <= hall_sign_i ^ hall_prev_ff;
            if (edge_sense_ff[`LHIC_BIT_FAULT]) begin
                position_zero_o <= role_ok[`LHIC_BIT_FAULT] & rise[`LHIC_BIT_FAULT];
            end else begin
                position_zero_o <= role_ok[`LHIC_BIT_FAULT] & fall[`LHIC_BIT_FAULT];
            end
        end
    end

    // Which switches the requested homing method cannot do without.
    always_comb begin
        need_lower = 1'b0;
        need_upper = 1'b0;
        need_home = 1'b0;
        case (homing_method_i)
            8'h01, 8'h11: need_lower = 1'b1;
            8'h02, 8'h12: need_upper = 1'b1;
            default: begin
                need_home = ((homing_method_i >= 8'h03) && (homing_method_i <= 8'h0E)) ||
                            ((homing_method_i >= 8'h13) && (homing_method_i <= 8'h1E));
            end
        endcase
    end

    // Homing start check; a start without its switches is turned away.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            homing_go_o <= 1'b0;
            homing_refused_o <= 1'b0;
        end else begin
            homing_go_o <= 1'b0;
            homing_refused_o <= 1'b0;
            if (homing_start_i) begin
                if ((need_lower && ((lower_sel_ff & role_ok) == 8'h00)) ||
                    (need_upper && ((upper_sel_ff & role_ok) == 8'h00)) ||
                    (need_home && ((homing_sel_ff & role_ok) == 8'h00))) begin
                    homing_refused_o <= 1'b1;
                end else begin
                    homing_go_o <= 1'b1;
                end
            end
        end
    end

    // Configuration is open only in profile position or profile velocity mode.
    assign cfg_open = (op_mode_i == `LHIC_MODE_PROFILE_POS) ||
                      (op_mode_i == `LHIC_MODE_PROFILE_VEL);
    assign hit_cfg = ((obj_index_i == `LHIC_IDX_INPUT_CFG) &&
                      (obj_sub_i inside {`LHIC_SUB_LOWER, `LHIC_SUB_UPPER, `LHIC_SUB_HOMING,
                                         `LHIC_SUB_EDGE, `LHIC_SUB_HLIMIT})) ||
                     (obj_index_i == `LHIC_IDX_THRESHOLD && obj_sub_i == `LHIC_SUB_COUNT) ||
                     (obj_index_i == `LHIC_IDX_FAULT_PIN && obj_sub_i == `LHIC_SUB_FAULT_FN);

    // Object read mux; unknown objects answer with an error.
    always_comb begin
        rd_val = 8'h00;
        rd_ok = 1'b1;
        case ({obj_index_i, obj_sub_i})
            {`LHIC_IDX_INPUT_CFG, `LHIC_SUB_COUNT}: rd_val = `LHIC_RST_COUNT;
            {`LHIC_IDX_INPUT_CFG, `LHIC_SUB_LOWER}: rd_val = lower_sel_ff;
            {`LHIC_IDX_INPUT_CFG, `LHIC_SUB_UPPER}: rd_val = upper_sel_ff;
            {`LHIC_IDX_INPUT_CFG, `LHIC_SUB_HOMING}: rd_val = homing_sel_ff;
            {`LHIC_IDX_INPUT_CFG, `LHIC_SUB_EDGE}: rd_val = edge_sense_ff;
            {`LHIC_IDX_INPUT_CFG, `LHIC_SUB_HLIMIT}: rd_val = hlimit_apply_ff;
            {`LHIC_IDX_INPUT_STAT, `LHIC_SUB_COUNT}: rd_val = `LHIC_STAT_COUNT;
            {`LHIC_IDX_INPUT_STAT, `LHIC_SUB_STAT_LOGIC}: rd_val = logic_mask;
            {`LHIC_IDX_INPUT_STAT, `LHIC_SUB_STAT_RAW}: rd_val = raw_mask;
            {`LHIC_IDX_FAULT_PIN, `LHIC_SUB_COUNT}: rd_val = `LHIC_FAULT_COUNT;
            {`LHIC_IDX_FAULT_PIN, `LHIC_SUB_FAULT_FN}: rd_val = fault_fn_ff;
            {`LHIC_IDX_THRESHOLD, `LHIC_SUB_COUNT}: rd_val = thresh_ff;
            default: rd_ok = 1'b0;
        endcase
    end
    assign wr_ok = hit_cfg && cfg_open;

    // Writable objects. Unused mask bits are kept so software reads back what it wrote.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lower_sel_ff <= `LHIC_RST_LOWER;
            upper_sel_ff <= `LHIC_RST_UPPER;
            homing_sel_ff <= `LHIC_RST_HOMING;
            edge_sense_ff <= `LHIC_RST_EDGE;
            hlimit_apply_ff <= `LHIC_RST_HLIMIT;
            thresh_ff <= `LHIC_RST_THRESH;
            fault_fn_ff <= `LHIC_RST_FAULT_FN;
        end else if (obj_wr_i && wr_ok) begin
            case ({obj_index_i, obj_sub_i})
                {`LHIC_IDX_INPUT_CFG, `LHIC_SUB_LOWER}: lower_sel_ff <= obj_wdata_i;
                {`LHIC_IDX_INPUT_CFG, `LHIC_SUB_UPPER}: upper_sel_ff <= obj_wdata_i;
                {`LHIC_IDX_INPUT_CFG, `LHIC_SUB_HOMING}: homing_sel_ff <= obj_wdata_i;
                {`LHIC_IDX_INPUT_CFG, `LHIC_SUB_EDGE}: edge_sense_ff <= obj_wdata_i;
                {`LHIC_IDX_INPUT_CFG, `LHIC_SUB_HLIMIT}: hlimit_apply_ff <= obj_wdata_i;
                {`LHIC_IDX_THRESHOLD, `LHIC_SUB_COUNT}: thresh_ff <= obj_wdata_i;
                {`LHIC_IDX_FAULT_PIN, `LHIC_SUB_FAULT_FN}: fault_fn_ff <= obj_wdata_i;
                default: ;
            endcase
        end
    end

    // One-cycle answer, registered one clock after the strobe.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ans_ff <= lhic_pkg::LHIC_ANS_NONE;
            rdata_ff <= 8'h00;
        end else if (obj_wr_i) begin
            ans_ff <= wr_ok ? lhic_pkg::LHIC_ANS_OK : lhic_pkg::LHIC_ANS_ERR;
            rdata_ff <= 8'h00;
        end else if (obj_rd_i) begin
            ans_ff <= rd_ok ? lhic_pkg::LHIC_ANS_OK : lhic_pkg::LHIC_ANS_ERR;
            rdata_ff <= rd_val;
        end else begin
            ans_ff <= lhic_pkg::LHIC_ANS_NONE;
            rdata_ff <= 8'h00;
        end
    end

    assign obj_ack_o = (ans_ff != lhic_pkg::LHIC_ANS_NONE);
    assign obj_err_o = (ans_ff == lhic_pkg::LHIC_ANS_ERR);
    assign obj_rdata_o = rdata_ff;
    assign thresh_24v_o = thresh_ff[0];
    assign fault_pin_is_input_o = (fault_fn_ff == `LHIC_FAULT_FN_REF);
endmodule : lhic_top

`default_nettype wire

// [dv/lhic_props.sv]
// Port-level checker for the limit and homing input block.
// Assumes it is bound to lhic_top and shares its single clock and reset.
`default_nettype none

module lhic_props (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic hall_sign_i,
    input wire logic [7:0] op_mode_i,
    input wire logic move_pos_req_i,
    input wire logic move_neg_req_i,
    input wire logic homing_start_i,
    input wire logic obj_wr_i,
    input wire logic obj_rd_i,
    input wire logic obj_ack_o,
    input wire logic obj_err_o,
    input wire logic thresh_24v_o,
    input wire logic fault_pin_is_input_o,
    input wire logic lower_limit_o,
    input wire logic upper_limit_o,
    input wire logic move_pos_en_o,
    input wire logic move_neg_en_o,
    input wire logic stop_o,
    input wire logic hall_index_o,
    input wire logic position_zero_o,
    input wire logic homing_go_o,
    input wire logic homing_refused_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // All checks run on the one clock and are silenced while reset is low.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // An object strobe is answered exactly one cycle after it is taken.
    sequence s_req;
        obj_wr_i || obj_rd_i;
    endsequence
    sequence s_ans;
        ##1 obj_ack_o;
    endsequence

    ack_on_req_a: assert property (s_req |-> s_ans) else $error("object ack missing");
    ack_no_req_a: assert property (!(obj_wr_i || obj_rd_i) |=> !obj_ack_o)
        else $error("object ack without request");
    err_with_ack_a: assert property (obj_err_o |-> obj_ack_o) else $error("err without ack");
    mode_refuse_a: assert property (obj_wr_i && op_mode_i != 8'h01 && op_mode_i != 8'h03
        |=> obj_err_o) else $error("write accepted outside profile modes");
    neg_gate_a: assert property (move_neg_en_o == (move_neg_req_i && !lower_limit_o))
        else $error("negative motion not blocked by lower limit");
    pos_gate_a: assert property (move_pos_en_o == (move_pos_req_i && !upper_limit_o))
        else $error("positive motion not blocked by upper limit");
    limit_stop_a: assert property ($rose(lower_limit_o) || $rose(upper_limit_o) |=> stop_o)
        else $error("no stop after limit became active");
    homing_answer_a: assert property (homing_start_i |=> homing_go_o != homing_refused_o)
        else $error("homing start without single answer");
    hall_pulse_a: assert property ($changed(hall_sign_i) |=> hall_index_o)
        else $error("no index pulse after hall change");
    zero_ref_a: assert property (position_zero_o |-> fault_pin_is_input_o)
        else $error("position zeroed while fault pin is not an input");
    thresh_hold_a: assert property (!obj_wr_i |=> $stable(thresh_24v_o))
        else $error("threshold changed without a write");
endmodule : lhic_props

bind lhic_top lhic_props chk_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .hall_sign_i(hall_sign_i), .op_mode_i(op_mode_i),
    .move_pos_req_i(move_pos_req_i), .move_neg_req_i(move_neg_req_i),
    .homing_start_i(homing_start_i), .obj_wr_i(obj_wr_i), .obj_rd_i(obj_rd_i),
    .obj_ack_o(obj_ack_o), .obj_err_o(obj_err_o), .thresh_24v_o(thresh_24v_o),
    .fault_pin_is_input_o(fault_pin_is_input_o), .lower_limit_o(lower_limit_o),
    .upper_limit_o(upper_limit_o), .move_pos_en_o(move_pos_en_o),
    .move_neg_en_o(move_neg_en_o), .stop_o(stop_o), .hall_index_o(hall_index_o),
    .position_zero_o(position_zero_o), .homing_go_o(homing_go_o),
    .homing_refused_o(homing_refused_o)
);

`default_nettype wire

// [dv/lhic_sw_model.sv]
// Model of the external switches on the analog, fault and third input pins.
// Assumes the bench names the wanted levels; the model enforces the hold time.
`default_nettype none

module lhic_sw_model #(
    parameter int HOLD = 10
) (
    input wire logic clk_i,
    input wire logic [2:0] want_i,
    output logic [2:0] pins_o
);
    timeunit 1ns;
    timeprecision 1ns;

    int hold_cnt = 0;

    // A new level is only applied once the last one has stood for HOLD + 1 cycles.
    // Real switches cannot chatter faster than this, so neither does the model.
    always @(posedge clk_i) begin
        if (hold_cnt != 0) begin
            hold_cnt <= hold_cnt - 1;
        end else if (want_i !== pins_o) begin
            pins_o <= want_i;
            hold_cnt <= HOLD;
        end
    end
endmodule : lhic_sw_model

`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for the limit and homing input block.
// Assumes lhic_top, the switch model and the bound checker are compiled first.
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SAMPLE = 8;
    localparam int HOLD = 10;

    logic clk_i, rst_n_i, hall_sign_i, move_pos_req_i, move_neg_req_i, homing_start_i;
    logic obj_wr_i, obj_rd_i, obj_ack_o, obj_err_o, thresh_24v_o, fault_pin_is_input_o;
    logic lower_limit_o, upper_limit_o, homing_lower_o, homing_upper_o, homing_switch_o;
    logic move_pos_en_o, move_neg_en_o, stop_o, hall_index_o, position_zero_o;
    logic homing_go_o, homing_refused_o, found, stop_seen;
    logic [7:0] op_mode_i, homing_method_i, obj_sub_i, obj_wdata_i, obj_rdata_o;
    logic [15:0] obj_index_i;
    logic [2:0] want, pins;
    int fails = 0;
    int tests_run = 0;
    logic [15:0] t_idx [10] = '{16'h2310, 16'h2310, 16'h2310, 16'h2310, 16'h2310,
        16'h2310, 16'h2316, 16'h2311, 16'h2315, 16'h2315};
    logic [7:0] t_sub [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h00, 8'h00,
        8'h00, 8'h01};
    logic [7:0] t_rst [10] = '{8'h06, 8'h00, 8'h00, 8'h07, 8'h07, 8'h00, 8'h01, 8'h04,
        8'h03, 8'h00};

    lhic_top #(.SAMPLE_CYC(SAMPLE)) dut_u (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .analog_input_pin_i(pins[0]),
        .fault_pin_i(pins[1]), .third_input_i(pins[2]), .hall_sign_i(hall_sign_i),
        .op_mode_i(op_mode_i), .move_pos_req_i(move_pos_req_i),
        .move_neg_req_i(move_neg_req_i), .homing_start_i(homing_start_i),
        .homing_method_i(homing_method_i), .obj_index_i(obj_index_i), .obj_sub_i(obj_sub_i),
        .obj_wr_i(obj_wr_i), .obj_rd_i(obj_rd_i), .obj_wdata_i(obj_wdata_i),
        .obj_ack_o(obj_ack_o), .obj_err_o(obj_err_o), .obj_rdata_o(obj_rdata_o),
        .thresh_24v_o(thresh_24v_o), .fault_pin_is_input_o(fault_pin_is_input_o),
        .lower_limit_o(lower_limit_o), .upper_limit_o(upper_limit_o),
        .homing_lower_o(homing_lower_o), .homing_upper_o(homing_upper_o),
        .homing_switch_o(homing_switch_o), .move_pos_en_o(move_pos_en_o),
        .move_neg_en_o(move_neg_en_o), .stop_o(stop_o), .hall_index_o(hall_index_o),
        .position_zero_o(position_zero_o), .homing_go_o(homing_go_o),
        .homing_refused_o(homing_refused_o)
    );

    lhic_sw_model #(.HOLD(HOLD)) sw_u (.clk_i(clk_i), .want_i(want), .pins_o(pins));

    // The 50 MHz clock.
    always #10 clk_i = ~clk_i;

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One object access; the answer stands only in the cycle after the taken edge.
    task automatic obj(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                       input logic [7:0] wd, input logic [7:0] e_err, input logic [7:0] e_rd);
        @(posedge clk_i);
        obj_wr_i <= wr;
        obj_rd_i <= !wr;
        obj_index_i <= idx;
        obj_sub_i <= sub;
        obj_wdata_i <= wd;
        @(posedge clk_i);
        obj_wr_i <= 1'b0;
        obj_rd_i <= 1'b0;
        #1;
        chk($sformatf("ack %h.%h", idx, sub), 8'h01, {7'h00, obj_ack_o});
        chk($sformatf("err %h.%h", idx, sub), e_err, {7'h00, obj_err_o});
        chk($sformatf("rdata %h.%h", idx, sub), e_rd, obj_rdata_o);
    endtask : obj

    task automatic home(input logic [7:0] m, input logic [7:0] e_go, input logic [7:0] e_ref);
        @(posedge clk_i);
        homing_method_i <= m;
        homing_start_i <= 1'b1;
        @(posedge clk_i);
        homing_start_i <= 1'b0;
        #1;
        chk($sformatf("go %h", m), e_go, {7'h00, homing_go_o});
        chk($sformatf("refused %h", m), e_ref, {7'h00, homing_refused_o});
    endtask : home

    // Long enough for the hold time, the synchronisers and one level tick.
    // The stop pulse stands one cycle, so it is latched while waiting.
    task automatic settle;
        stop_seen = 1'b0;
        repeat (SAMPLE + HOLD + 6) begin
            @(posedge clk_i);
            #1;
            if (stop_o === 1'b1) begin
                stop_seen = 1'b1;
            end
        end
    endtask : settle

    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    // A hang is cut off far beyond the few hundred cycles the tests need.
    initial begin
        #200000;
        fails++;
        end_sim();
    end

    // Main sequence: reset, register table, refusals, homing, limits, index, threshold.
    initial begin
        clk_i = 1'b0;
        rst_n_i = 1'b0;
        hall_sign_i = 1'b0;
        op_mode_i = 8'h01;
        move_pos_req_i = 1'b1;
        move_neg_req_i = 1'b1;
        homing_start_i = 1'b0;
        homing_method_i = 8'h00;
        obj_index_i = 16'h0000;
        obj_sub_i = 8'h00;
        obj_wr_i = 1'b0;
        obj_rd_i = 1'b0;
        obj_wdata_i = 8'h00;
        want = 3'h0;
        found = 1'b0;
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            obj(1'b0, t_idx[i], t_sub[i], 8'h00, 8'h00, t_rst[i]);
        end
        obj(1'b0, 16'h2399, 8'h00, 8'h00, 8'h01, 8'h00);
        obj(1'b1, 16'h2310, 8'h00, 8'h55, 8'h01, 8'h00);
        obj(1'b1, 16'h2310, 8'h04, 8'h01, 8'h01, 8'h00);
        op_mode_i <= 8'h06;
        obj(1'b1, 16'h2310, 8'h01, 8'h01, 8'h01, 8'h00);
        op_mode_i <= 8'h03;
        obj(1'b0, 16'h2310, 8'h01, 8'h00, 8'h00, 8'h00);
        home(8'h01, 8'h00, 8'h01);
        home(8'h11, 8'h00, 8'h01);
        home(8'h03, 8'h01, 8'h00);
        obj(1'b1, 16'h2310, 8'h01, 8'h01, 8'h00, 8'h00);
        home(8'h01, 8'h01, 8'h00);
        // Analog pin as lower limit, first active high, then inverted by edge sense.
        want <= 3'h1;
        settle();
        chk("lower", 8'h01, {7'h00, lower_limit_o});
        chk("neg_en", 8'h00, {7'h00, move_neg_en_o});
        chk("pos_en", 8'h01, {7'h00, move_pos_en_o});
        chk("stop", 8'h01, {7'h00, stop_seen});
        chk("home_low", 8'h01, {7'h00, homing_lower_o});
        chk("home_sw", 8'h01, {7'h00, homing_switch_o});
        obj(1'b0, 16'h2311, 8'h02, 8'h00, 8'h00, 8'h01);
        obj(1'b1, 16'h2310, 8'h05, 8'h06, 8'h00, 8'h00);
        obj(1'b0, 16'h2311, 8'h01, 8'h00, 8'h00, 8'h00);
        chk("lower inv", 8'h00, {7'h00, lower_limit_o});
        chk("home_low pos", 8'h01, {7'h00, homing_lower_o});
        obj(1'b1, 16'h2310, 8'h06, 8'h01, 8'h00, 8'h00);
        chk("home_low pol", 8'h00, {7'h00, homing_lower_o});
        chk("home_sw raw", 8'h01, {7'h00, homing_switch_o});
        obj(1'b1, 16'h2310, 8'h06, 8'h00, 8'h00, 8'h00);
        want <= 3'h0;
        settle();
        chk("lower low", 8'h01, {7'h00, lower_limit_o});
        chk("stop low", 8'h01, {7'h00, stop_seen});
        obj(1'b1, 16'h2310, 8'h05, 8'h07, 8'h00, 8'h00);
        obj(1'b1, 16'h2310, 8'h01, 8'h00, 8'h00, 8'h00);
        // Fault pin as upper limit counts only once it is a reference input.
        obj(1'b1, 16'h2310, 8'h02, 8'h02, 8'h00, 8'h00);
        want <= 3'h2;
        settle();
        chk("upper fn0", 8'h00, {7'h00, upper_limit_o});
        obj(1'b1, 16'h2315, 8'h01, 8'h04, 8'h00, 8'h00);
        chk("fault in", 8'h01, {7'h00, fault_pin_is_input_o});
        chk("upper fn4", 8'h01, {7'h00, upper_limit_o});
        chk("home_up", 8'h01, {7'h00, homing_upper_o});
        chk("pos_en", 8'h00, {7'h00, move_pos_en_o});
        // Third input by level, then a rising index edge on the fault pin.
        obj(1'b1, 16'h2310, 8'h02, 8'h04, 8'h00, 8'h00);
        want <= 3'h4;
        settle();
        chk("upper third", 8'h01, {7'h00, upper_limit_o});
        obj(1'b0, 16'h2311, 8'h02, 8'h00, 8'h00, 8'h04);
        want <= 3'h6;
        repeat (20) begin
            @(posedge clk_i);
            #1;
            if (position_zero_o === 1'b1) begin
                found = 1'b1;
            end
        end
        chk("zero", 8'h01, {7'h00, found});
        obj(1'b1, 16'h2316, 8'h00, 8'h00, 8'h00, 8'h00);
        chk("thresh", 8'h00, {7'h00, thresh_24v_o});
        obj(1'b0, 16'h2316, 8'h00, 8'h00, 8'h00, 8'h00);
        @(posedge clk_i);
        hall_sign_i <= 1'b1;
        @(posedge clk_i);
        #1;
        chk("hall", 8'h01, {7'h00, hall_index_o});
        repeat (4) @(posedge clk_i);
        end_sim();
    end
endmodule : tb

`default_nettype wire
